// File: bld_pkg.sv
// Constants, register map and shared types of the backlight register bank.
// Assumes nothing of its surroundings; imported whole by every design module.
`default_nettype none

package bld_pkg;

  typedef logic [7:0] bld_byte_t;

  // Device address on the two-wire bus
  localparam logic [6:0] BUS_ADDR = 7'h36;
  // Silicon revision, arbitrary value
  localparam bld_byte_t REV_CODE = 8'h05;

  localparam int NREG = 23;

  localparam int IDX_REV      = 0;
  localparam int IDX_SWRST    = 1;
  localparam int IDX_ASSIGN   = 2;
  localparam int IDX_SSR_A    = 3;
  localparam int IDX_SSR_B    = 4;
  localparam int IDX_RT_TIME  = 5;
  localparam int IDX_RT_SEL   = 6;
  localparam int IDX_RSVD     = 7;
  localparam int IDX_BRT_CFG  = 8;
  localparam int IDX_FS_A     = 9;
  localparam int IDX_FS_B     = 10;
  localparam int IDX_FB_EN    = 11;
  localparam int IDX_BOOST    = 12;
  localparam int IDX_AF_THR   = 13;
  localparam int IDX_PULSE    = 14;
  localparam int IDX_BRT_LO_A = 15;
  localparam int IDX_BRT_HI_A = 16;
  localparam int IDX_BRT_LO_B = 17;
  localparam int IDX_BRT_HI_B = 18;
  localparam int IDX_BANK_EN  = 19;
  localparam int IDX_OPEN     = 20;
  localparam int IDX_SHORT    = 21;
  localparam int IDX_FLT_EN   = 22;

  localparam bld_byte_t REG_ADDR [NREG] = '{
    8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19,
    8'h1A, 8'h1B, 8'h1C, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'hB0, 8'hB2, 8'hB4};
  localparam bld_byte_t REG_RST [NREG] = '{
    REV_CODE, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h33, 8'h00, 8'h13, 8'h13, 8'h07,
    8'h00, 8'hCF, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Writable bits; all others except the fault flags read back their reset value (zero when unused)
  localparam bld_byte_t REG_WMASK [NREG] = '{
    8'h00, 8'h00, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h0D, 8'h1F, 8'h1F, 8'h07,
    8'h1F, 8'hFF, 8'h0F, 8'h07, 8'hFF, 8'h07, 8'hFF, 8'h03, 8'h00, 8'h00, 8'h03};

  // Field positions
  localparam int SWRST_BIT     = 0;
  localparam int LIN_MAP_BIT   = 0;
  localparam int DITHER_A_BIT  = 2;
  localparam int BST_FREQ_BIT  = 0;
  localparam int OVP_LSB       = 1;
  localparam int AUTO_FREQ_BIT = 3;
  localparam int AUTO_HR_BIT   = 4;
  localparam int PLS_POL_BIT   = 2;
  localparam int PLS_ZERO_BIT  = 3;
  localparam int FLT_OPEN_BIT  = 0;
  localparam int FLT_SHORT_BIT = 1;
  localparam int RAMP_UP_LSB   = 4;
  localparam int RAMP_DN_LSB   = 0;
  localparam int FS_W          = 5;
  localparam int CODE_W        = 11;
  localparam int LOW_W         = 3;

  // Linear current scale in microamps
  localparam logic [15:0] FS_BASE_UA = 16'h1388;
  localparam logic [15:0] FS_STEP_UA = 16'h0320;
  localparam logic [25:0] CODE_FULL  = 26'h00007FF;

  typedef enum logic [4:0] {
    PH_ADDR = 5'h01,
    PH_REG  = 5'h02,
    PH_DATA = 5'h04,
    PH_READ = 5'h08,
    PH_IDLE = 5'h10
  } bld_phase_e;

  typedef struct packed {
    logic      is_data;
    bld_byte_t addr;
    bld_byte_t data;
  } bld_wr_s;

endpackage

`default_nettype wire

// File: bld_link.sv
// Two-wire bus slave engine clocked by the bus clock itself.
// Assumes frame_rst_n_in is held low outside frames and released while the bus clock is low.
`default_nettype none
`timescale 1ns/1ps

module bld_link
  import bld_pkg::*;
(
  // Clocks and resets
  input  wire logic      scl_clk_in,
  input  wire logic      nrst_in,
  input  wire logic      frame_rst_n_in,
  // Bus data pin
  input  wire logic      sda_in,
  output logic           sda_out,
  output logic           sda_oe_out,
  // Core side
  input  wire bld_byte_t rd_data_in,
  output bld_wr_s        wr_out,
  output logic           wr_tgl_out
);

  bld_phase_e phase_r, phase_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  bld_byte_t  shift_r, shift_nxt, byte_v, tx_r, tx_nxt;
  logic       ack_r, ack_nxt, oe_r, oe_nxt, tgl_nxt;
  bld_wr_s    wr_nxt;

  always_comb begin
    byte_v      = {shift_r[6:0], sda_in};
    phase_nxt   = phase_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    ack_nxt     = 1'b0;
    wr_nxt      = wr_out;
    tgl_nxt     = wr_tgl_out;
    if (bit_cnt_r == 4'h8) begin
      bit_cnt_nxt = 4'h0;
      // Host not acknowledging a read byte ends the read
      if ((phase_r == PH_READ) && sda_in) begin
        phase_nxt = PH_IDLE;
      end
    end else begin
      shift_nxt   = byte_v;
      bit_cnt_nxt = bit_cnt_r + 4'h1;
      if (bit_cnt_r == 4'h7) begin
        unique case (phase_r)
          PH_ADDR: begin
            if (byte_v[7:1] == BUS_ADDR) begin
              phase_nxt = byte_v[0] ? PH_READ : PH_REG;
              ack_nxt   = 1'b1;
            end else begin
              phase_nxt = PH_IDLE;
            end
          end
          PH_REG: begin
            wr_nxt    = '{is_data: 1'b0, addr: byte_v, data: wr_out.data};
            tgl_nxt   = ~wr_tgl_out;
            ack_nxt   = 1'b1;
            phase_nxt = PH_DATA;
          end
          PH_DATA: begin
            wr_nxt  = '{is_data: 1'b1, addr: wr_out.addr, data: byte_v};
            tgl_nxt = ~wr_tgl_out;
            ack_nxt = 1'b1;
          end
          PH_READ, PH_IDLE: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge scl_clk_in or negedge frame_rst_n_in) begin
    if (!frame_rst_n_in) begin
      phase_r   <= PH_ADDR;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      ack_r     <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r   <= shift_nxt;
      ack_r     <= ack_nxt;
    end
  end

  // The write event must survive frame ends, so it only sees the core reset
  always_ff @(posedge scl_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_out     <= '0;
      wr_tgl_out <= 1'b0;
    end else begin
      wr_out     <= wr_nxt;
      wr_tgl_out <= tgl_nxt;
    end
  end

  // Drive side changes only while the bus clock is low
  always_comb begin
    oe_nxt = 1'b0;
    tx_nxt = tx_r;
    if (bit_cnt_r == 4'h8) begin
      oe_nxt = ack_r;
    end else if (phase_r == PH_READ) begin
      if (bit_cnt_r == 4'h0) begin
        tx_nxt = rd_data_in;
        oe_nxt = ~rd_data_in[7];
      end else begin
        tx_nxt = {tx_r[6:0], 1'b0};
        oe_nxt = ~tx_r[6];
      end
    end
  end

  always_ff @(negedge scl_clk_in or negedge frame_rst_n_in) begin
    if (!frame_rst_n_in) begin
      oe_r    <= 1'b0;
      tx_r    <= 8'h00;
      sda_out <= 1'b0;
    end else begin
      oe_r    <= oe_nxt;
      tx_r    <= tx_nxt;
      sda_out <= 1'b0;
    end
  end

  assign sda_oe_out = oe_r;

endmodule // bld_link

`default_nettype wire

// File: bld_regbank.sv
// Register bank of a three-string backlight driver, reached over a two-wire bus.
// Assumes analog comparators and the pulse input are asynchronous; the bus clock is its own domain.
`default_nettype none
`timescale 1ns/1ps

module bld_regbank
  import bld_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                   core_clk_in,
  input  wire logic                   nrst_in,
  input  wire logic                   ce_in,
  // Two-wire bus
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe_out,
  // Device pins and analog status
  input  wire logic                   hardware_enable_pin_in,
  input  wire logic                   pulse_in,
  input  wire logic                   overvoltage_limit_in,
  input  wire logic [2:0]             sink_low_in,
  input  wire logic [2:0]             sink_short_in,
  // Sink and bank controls
  output logic [2:0]                  sink_bank_sel_out,
  output logic [1:0]                  bank_enable_out,
  output logic [1:0][CODE_W-1:0]      bank_code_out,
  output logic [1:0]                  bank_code_load_out,
  output logic [1:0][3:0]             ramp_up_code_out,
  output logic [1:0][3:0]             ramp_down_code_out,
  output logic [1:0]                  ramp_immediate_out,
  output logic [1:0][3:0]             startup_code_out,
  output logic [1:0][3:0]             shutdown_code_out,
  output logic                        linear_map_out,
  output logic [1:0]                  dither_en_out,
  output logic [1:0][FS_W-1:0]        fullscale_code_out,
  output logic [2:0][15:0]            sink_current_ua_out,
  // Boost controls
  output logic [2:0]                  feedback_en_out,
  output logic [1:0]                  overvoltage_limit_sel_out,
  output logic                        boost_freq_1mhz_out,
  output logic                        auto_freq_en_out,
  output logic                        auto_headroom_en_out,
  output logic [7:0]                  auto_freq_thresh_out,
  // Pulse input controls
  output logic                        pulse_active_high_out,
  output logic                        pulse_zero_detect_out,
  output logic [1:0]                  pulse_bank_en_out
);

  localparam int SW      = 12;
  localparam int S_SCL   = 0;
  localparam int S_SDA   = 1;
  localparam int S_HARDWARE_ENABLE_PIN  = 2;
  localparam int S_PULSE = 3;
  localparam int S_OVP   = 4;
  localparam int S_LOW   = 5;
  localparam int S_SHORT = 8;
  localparam int S_TGL   = 11;

  logic [SW-1:0] raw, meta_r, sync_r;
  bld_wr_s       link_wr;
  logic          link_tgl, link_rst_n;

  // Pin and crossing synchronisers
  assign raw = {link_tgl, sink_short_in, sink_low_in, overvoltage_limit_in, pulse_in,
                hardware_enable_pin_in, sda_in, scl_in};

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (ce_in) begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  // Bus frame tracking and write event capture
  logic      sda_prev_r, sda_prev_nxt, tgl_prev_r, tgl_prev_nxt;
  logic      hold_r, hold_nxt, armed_r, armed_nxt;
  bld_byte_t ptr_r, ptr_nxt, rd_word_r, rd_word_nxt;
  logic      start_det, stop_det, wr_fire, reg_wr, sw_rst, clr_all;

  assign start_det = sync_r[S_SCL] & sda_prev_r & ~sync_r[S_SDA];
  assign stop_det  = sync_r[S_SCL] & ~sda_prev_r & sync_r[S_SDA];
  assign wr_fire   = ce_in & (sync_r[S_TGL] != tgl_prev_r);
  // The write word is held stable by the link for a whole byte time after its toggle
  assign reg_wr    = wr_fire & link_wr.is_data;
  assign sw_rst    = reg_wr & (link_wr.addr == REG_ADDR[IDX_SWRST])
                     & link_wr.data[SWRST_BIT];
  assign clr_all   = sw_rst | ~sync_r[S_HARDWARE_ENABLE_PIN];
  // Link logic sits in reset between frames and is released with the bus clock low
  assign link_rst_n = nrst_in & ~hold_r;

  always_comb begin
    sda_prev_nxt = sync_r[S_SDA];
    tgl_prev_nxt = sync_r[S_TGL];
    hold_nxt     = hold_r;
    armed_nxt    = armed_r;
    ptr_nxt      = ptr_r;
    if (stop_det) begin
      hold_nxt  = 1'b1;
      armed_nxt = 1'b0;
    end else if (start_det) begin
      hold_nxt  = 1'b1;
      armed_nxt = 1'b1;
    end else if (armed_r && !sync_r[S_SCL]) begin
      hold_nxt  = 1'b0;
      armed_nxt = 1'b0;
    end
    if (wr_fire) begin
      ptr_nxt = link_wr.addr;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sda_prev_r <= 1'b0;
      tgl_prev_r <= 1'b0;
      hold_r     <= 1'b1;
      armed_r    <= 1'b0;
      ptr_r      <= 8'h00;
    end else if (ce_in) begin
      sda_prev_r <= sda_prev_nxt;
      tgl_prev_r <= tgl_prev_nxt;
      hold_r     <= hold_nxt;
      armed_r    <= armed_nxt;
      ptr_r      <= ptr_nxt;
    end
  end

  bld_link u_link (
    .scl_clk_in     (scl_in),
    .nrst_in        (nrst_in),
    .frame_rst_n_in (link_rst_n),
    .sda_in         (sda_in),
    .sda_out        (sda_out),
    .sda_oe_out     (sda_oe_out),
    .rd_data_in     (rd_word_r),
    .wr_out         (link_wr),
    .wr_tgl_out     (link_tgl)
  );

  // Register file
  bld_byte_t  regs_r   [NREG];
  bld_byte_t  regs_nxt [NREG];
  logic [2:0] sink_active, open_set, short_set;

  for (genvar k = 0; k < 3; k++) begin : g_sink_flt
    assign sink_active[k] = regs_r[IDX_BANK_EN][regs_r[IDX_ASSIGN][k]];
    assign open_set[k]  = regs_r[IDX_FLT_EN][FLT_OPEN_BIT] & sink_active[k]
                          & regs_r[IDX_FB_EN][k] & sync_r[S_LOW+k]
                          & sync_r[S_OVP];
    assign short_set[k] = regs_r[IDX_FLT_EN][FLT_SHORT_BIT] & sink_active[k]
                          & sync_r[S_SHORT+k];
  end

  for (genvar i = 0; i < NREG; i++) begin : g_reg
    always_comb begin
      regs_nxt[i] = regs_r[i];
      if (reg_wr && (link_wr.addr == REG_ADDR[i])) begin
        regs_nxt[i] = (regs_r[i] & ~REG_WMASK[i]) | (link_wr.data & REG_WMASK[i]);
      end
      if (i == IDX_OPEN) begin
        // Flags persist until detection is disabled; a new fault sets unless clr_all clears the bank in the same cycle
        regs_nxt[i] = regs_r[IDX_FLT_EN][FLT_OPEN_BIT] ? (regs_r[i] | {5'h00, open_set})
                      : 8'h00;
      end
      if (i == IDX_SHORT) begin
        regs_nxt[i] = regs_r[IDX_FLT_EN][FLT_SHORT_BIT] ? (regs_r[i] | {5'h00, short_set})
                      : 8'h00;
      end
      if (clr_all) begin
        regs_nxt[i] = REG_RST[i];
      end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        regs_r[i] <= REG_RST[i];
      end else if (ce_in) begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  always_comb begin
    rd_word_nxt = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (ptr_r == REG_ADDR[i]) begin
        rd_word_nxt = regs_r[i];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_word_r <= 8'h00;
    end else if (ce_in) begin
      rd_word_r <= rd_word_nxt;
    end
  end

  // Applied brightness per bank
  logic [1:0][CODE_W-1:0] code_nxt;
  logic [1:0]             load_nxt;
  logic [1:0][15:0]       level;
  logic                   pulse_act;

  assign pulse_act = sync_r[S_PULSE] == regs_r[IDX_PULSE][PLS_POL_BIT];

  for (genvar b = 0; b < 2; b++) begin : g_bank
    localparam int LO = IDX_BRT_LO_A + 2 * b;
    localparam int HI = IDX_BRT_HI_A + 2 * b;
    logic [15:0] fs_ua;
    logic [25:0] prod;

    always_comb begin
      code_nxt[b] = bank_code_out[b];
      load_nxt[b] = 1'b0;
      // A low-byte write only updates its register; the code moves on the high byte
      if (reg_wr && (link_wr.addr == REG_ADDR[HI])) begin
        code_nxt[b] = {link_wr.data, regs_r[LO][LOW_W-1:0]};
        load_nxt[b] = 1'b1;
      end
      if (clr_all) begin
        code_nxt[b] = '0;
        load_nxt[b] = 1'b0;
      end
    end

    assign fs_ua = FS_BASE_UA + FS_STEP_UA * {11'h000, regs_r[IDX_FS_A+b][FS_W-1:0]};
    assign prod  = {10'h000, fs_ua} * {15'h0000, bank_code_out[b]};
    assign level[b] = 16'(prod / CODE_FULL);
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bank_code_out      <= '0;
      bank_code_load_out <= 2'h0;
    end else if (ce_in) begin
      bank_code_out      <= code_nxt;
      bank_code_load_out <= load_nxt;
    end
  end

  // Registered configuration decode
  logic [1:0][3:0]  up_nxt, dn_nxt, su_nxt, sd_nxt;
  logic [1:0]       imm_nxt;
  logic [2:0][15:0] cur_nxt;

  always_comb begin
    for (int b = 0; b < 2; b++) begin
      su_nxt[b]  = regs_r[IDX_SSR_A+b][RAMP_UP_LSB +: 4];
      sd_nxt[b]  = regs_r[IDX_SSR_A+b][RAMP_DN_LSB +: 4];
      up_nxt[b]  = regs_r[IDX_RT_TIME][RAMP_UP_LSB +: 4];
      dn_nxt[b]  = regs_r[IDX_RT_TIME][RAMP_DN_LSB +: 4];
      imm_nxt[b] = regs_r[IDX_RT_SEL][2*b+1];
      if (regs_r[IDX_RT_SEL][2*b+:2] == 2'h1) begin
        up_nxt[b] = su_nxt[b];
        dn_nxt[b] = sd_nxt[b];
      end
    end
    for (int k = 0; k < 3; k++) begin
      cur_nxt[k] = 16'h0000;
      // Exponential mapping is left to the analog sink; only linear is computed here
      if (sink_active[k] && regs_r[IDX_BRT_CFG][LIN_MAP_BIT]
          && (!regs_r[IDX_PULSE][regs_r[IDX_ASSIGN][k]] || pulse_act)) begin
        cur_nxt[k] = level[regs_r[IDX_ASSIGN][k]];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ramp_up_code_out    <= '0;
      ramp_down_code_out  <= '0;
      startup_code_out    <= '0;
      shutdown_code_out   <= '0;
      ramp_immediate_out  <= 2'h0;
      dither_en_out       <= 2'h3;
      sink_current_ua_out <= '0;
    end else if (ce_in) begin
      ramp_up_code_out    <= up_nxt;
      ramp_down_code_out  <= dn_nxt;
      startup_code_out    <= su_nxt;
      shutdown_code_out   <= sd_nxt;
      ramp_immediate_out  <= imm_nxt;
      dither_en_out       <= ~regs_r[IDX_BRT_CFG][DITHER_A_BIT +: 2];
      sink_current_ua_out <= cur_nxt;
    end
  end

  // Plain fields straight from the register flops
  assign sink_bank_sel_out         = regs_r[IDX_ASSIGN][2:0];
  assign bank_enable_out           = regs_r[IDX_BANK_EN][1:0];
  assign linear_map_out            = regs_r[IDX_BRT_CFG][LIN_MAP_BIT];
  assign fullscale_code_out[0]     = regs_r[IDX_FS_A][FS_W-1:0];
  assign fullscale_code_out[1]     = regs_r[IDX_FS_B][FS_W-1:0];
  assign feedback_en_out           = regs_r[IDX_FB_EN][2:0];
  assign overvoltage_limit_sel_out = regs_r[IDX_BOOST][OVP_LSB +: 2];
  assign boost_freq_1mhz_out       = regs_r[IDX_BOOST][BST_FREQ_BIT];
  assign auto_freq_en_out          = regs_r[IDX_BOOST][AUTO_FREQ_BIT];
  assign auto_headroom_en_out      = regs_r[IDX_BOOST][AUTO_HR_BIT];
  assign auto_freq_thresh_out      = regs_r[IDX_AF_THR];
  assign pulse_active_high_out     = regs_r[IDX_PULSE][PLS_POL_BIT];
  assign pulse_zero_detect_out     = regs_r[IDX_PULSE][PLS_ZERO_BIT];
  assign pulse_bank_en_out         = regs_r[IDX_PULSE][1:0];

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  a_swrst_restores: assert property (sw_rst |=> regs_r[IDX_ASSIGN] == 8'h06
    && regs_r[IDX_FS_A] == 8'h13 && regs_r[IDX_PULSE] == 8'h0C && regs_r[IDX_SWRST] == 8'h00)
    else $error("soft reset did not restore registers");
  a_thresh_reset: assert property (clr_all && ce_in |=> regs_r[IDX_AF_THR] == 8'hCF)
    else $error("threshold reset value wrong");
  a_low_held: assert property (reg_wr && link_wr.addr == REG_ADDR[IDX_BRT_LO_A] && !clr_all
    |=> $stable(bank_code_out[0]) && !bank_code_load_out[0])
    else $error("low brightness write changed code");
  a_high_applies: assert property (reg_wr && link_wr.addr == REG_ADDR[IDX_BRT_HI_B] && !clr_all
    |=> bank_code_out[1] == {$past(link_wr.data), $past(regs_r[IDX_BRT_LO_B][2:0])}
    && bank_code_load_out[1] ##1 !bank_code_load_out[1] || !$past(ce_in, 1))
    else $error("high brightness write not applied");
  a_ramp_immediate: assert property (ce_in && regs_r[IDX_RT_SEL][3] |=> ramp_immediate_out[1])
    else $error("immediate ramp select ignored");
  a_dither_map: assert property (ce_in |=> dither_en_out[0] == !$past(regs_r[IDX_BRT_CFG][2]))
    else $error("dither enable mismatch");
  a_open_sets: assert property (ce_in && open_set[1] && !clr_all |=> regs_r[IDX_OPEN][1])
    else $error("open fault not flagged");
  a_short_sets: assert property (ce_in && short_set[2] && !clr_all |=> regs_r[IDX_SHORT][2])
    else $error("short fault not flagged");
  a_unused_zero: assert property (regs_r[IDX_BANK_EN][7:2] == 6'h00
    && regs_r[IDX_BOOST][7:5] == 3'h0 && regs_r[IDX_REV][7:4] == 4'h0)
    else $error("unused bits not zero");
  a_off_no_current: assert property (ce_in && !sink_active[0] |=> sink_current_ua_out[0] == 16'h0000)
    else $error("current on disabled sink");

endmodule // bld_regbank

`default_nettype wire

// File: bld_host.sv
// Two-wire bus host model: write and read frames at an 8 MHz bus clock.
// Assumes an open-drain data line with a pull-up, resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module bld_host
  import bld_pkg::*;
(
  // Bus pins
  output logic      scl_out,
  output logic      sda_oe_out,
  input  wire logic sda_in
);
  // Clock stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic bt(input logic b, output logic r);
    #31.25 sda_oe_out = ~b;
    #31.25 scl_out = 1'b1;
    #31.25 r = sda_in;
    #31.25 scl_out = 1'b0;
  endtask
  task automatic by(input logic [7:0] d, output logic [7:0] q, inout logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(1'b1, r);
    nak = nak | r;
  endtask
  // Same sequence serves as first and repeated start
  task automatic sta;
    #31.25 sda_oe_out = 1'b0;
    #31.25 scl_out = 1'b1;
    #31.25 sda_oe_out = 1'b1;
    #31.25 scl_out = 1'b0;
  endtask
  task automatic sto;
    #31.25 sda_oe_out = 1'b1;
    #31.25 scl_out = 1'b1;
    #31.25 sda_oe_out = 1'b0;
    #62.5;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, dt, output logic nak);
    logic [7:0] q;
    nak = 1'b0;
    sta;
    by({dev, 1'b0}, q, nak);
    by(ra, q, nak);
    by(dt, q, nak);
    sto;
  endtask
  task automatic rd(input logic [7:0] ra, output logic [7:0] q);
    logic nak;
    nak = 1'b0;
    sta;
    by({BUS_ADDR, 1'b0}, q, nak);
    by(ra, q, nak);
    sta;
    by({BUS_ADDR, 1'b1}, q, nak);
    by(8'hFF, q, nak);
    sto;
  endtask
endmodule // bld_host
`default_nettype wire

// File: test_bld_regbank.sv
// Bench for the backlight register bank, driven through the host model.
// Assumes the data line is open drain with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module test_bld_regbank
  import bld_pkg::*;
;
  logic                   clk;
  logic                   nrst = 1'b0;
  logic                   pls = 1'b0;
  logic                   hardware_enable_pin = 1'b1;
  logic                   ce = 1'b1;
  logic                   ovl = 1'b0;
  logic [2:0]             slo = 3'h0;
  logic [2:0]             ssh = 3'h0;
  logic [2:0]             sel;
  logic                   scl, hoe, doe, dsd, sda, nak, lin;
  logic [1:0]             dith, ovs;
  logic [1:0][CODE_W-1:0] code;
  logic [2:0][15:0]       cur;
  logic [7:0]             q;
  int                     fails = 0;
  int                     checks_done = 0;
  assign sda = ~hoe & ~(doe & ~dsd);
  bld_host host (.scl_out(scl), .sda_oe_out(hoe), .sda_in(sda));
  bld_regbank uut (
    .core_clk_in(clk), .nrst_in(nrst), .ce_in(ce), .scl_in(scl), .sda_in(sda),
    .sda_out(dsd), .sda_oe_out(doe), .hardware_enable_pin_in(hardware_enable_pin), .pulse_in(pls),
    .overvoltage_limit_in(ovl), .sink_low_in(slo), .sink_short_in(ssh),
    .sink_bank_sel_out(sel), .bank_enable_out(), .bank_code_out(code),
    .bank_code_load_out(), .ramp_up_code_out(), .ramp_down_code_out(),
    .ramp_immediate_out(), .startup_code_out(), .shutdown_code_out(),
    .linear_map_out(lin), .dither_en_out(dith), .fullscale_code_out(),
    .sink_current_ua_out(cur), .feedback_en_out(), .overvoltage_limit_sel_out(ovs),
    .boost_freq_1mhz_out(), .auto_freq_en_out(), .auto_headroom_en_out(),
    .auto_freq_thresh_out(), .pulse_active_high_out(), .pulse_zero_detect_out(),
    .pulse_bank_en_out());
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, e);
    host.rd(a, q);
    chk(q, e);
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    $display("BAD %0t timeout", $time);
    fails++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk(dith, 2'b11);
    chk(sel, 3'b110);
    for (int i = 0; i < NREG; i++) rchk(REG_ADDR[i], REG_RST[i]);
    $display("reset test done");
    // Pulse input stays inactive while its enables are set
    for (int i = 2; i < NREG; i++) host.wr(BUS_ADDR, REG_ADDR[i], 8'hFF, nak);
    for (int i = 2; i < NREG; i++) rchk(REG_ADDR[i], REG_RST[i] | REG_WMASK[i]);
    chk(lin, 1'b1);
    chk(dith, 2'b00);
    chk(ovs, 2'b11);
    chk(code[0], 11'h7FF);
    chk(cur[2], 16'h0000);
    @(posedge clk) pls <= 1'b1;
    repeat (6) @(posedge clk);
    chk(cur[2], 16'h7468);
    // Clock enable low must freeze the pulse gating
    ce <= 1'b0;
    pls <= 1'b0;
    repeat (6) @(posedge clk);
    chk(cur[2], 16'h7468);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    chk(cur[2], 16'h0000);
    $display("write test done");
    host.wr(BUS_ADDR, 8'h20, 8'h05, nak);
    chk(code[0], 11'h7FF);
    host.wr(BUS_ADDR, 8'h21, 8'h80, nak);
    chk(code[0], 11'h405);
    @(posedge clk) ovl <= 1'b1;
    slo <= 3'b011;
    ssh <= 3'b100;
    rchk(8'hB0, 8'h03);
    rchk(8'hB2, 8'h04);
    host.wr(BUS_ADDR, 8'h30, 8'h55, nak);
    rchk(8'h30, 8'h00);
    host.wr(7'h37, 8'h1B, 8'h12, nak);
    chk(nak, 1'b1);
    rchk(8'h1B, 8'hFF);
    host.wr(BUS_ADDR, 8'h01, 8'h01, nak);
    rchk(8'h01, 8'h00);
    rchk(8'h1B, 8'hCF);
    chk(code[0], 11'h000);
    // Hardware enable low returns registers to reset
    host.wr(BUS_ADDR, 8'h1B, 8'h12, nak);
    rchk(8'h1B, 8'h12);
    @(posedge clk) hardware_enable_pin <= 1'b0;
    repeat (4) @(posedge clk);
    hardware_enable_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(8'h1B, 8'hCF);
    $display("code and fault test done");
    end_sim;
  end
endmodule // test_bld_regbank
`default_nettype wire
